/* pkg/adcpm_pkg.sv */
// constants and types for the adc power-mode and clock-mode control block
// Notes on behaviour
// - power-up in internal clock mode, strobe high
// - first one on data input starts byte
// - zeros shift out before first conversion
// - mode taken from control byte bits 1:0
// - 00 deep, 01 quick, 10 internal, 11 external
// - sleeping keeps serial interface, no conversions
// - hard power-down overrides mode bits always
// - deep sleep core and bandgap off, quick keeps bandgap
// - pin high: internal compensation, 225 kHz clock
// - pin floating: external compensation, 1.8 MHz clock
// - sleep request finishes conversion in previous mode
// - result stays readable during software sleep
// - a complete byte wakes; its mode bits decide sleep
// - mode 00 converts once then sleeps again
// - hard power-down aborts conversion at once
// - conversion starts after eighth control byte bit
// - strobe low during internal-clock conversion only
package adcpm_pkg;

    localparam int unsigned CLK_HZ         = 100_000_000;
    localparam int unsigned POR_TIME_NS    = 10_000;
    localparam int unsigned POR_CYCLES     = (POR_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned INT_SLOW_HZ    = 225_000;
    localparam int unsigned INT_FAST_HZ    = 1_800_000;
    localparam int unsigned DIV_SLOW       = CLK_HZ / INT_SLOW_HZ;
    localparam int unsigned DIV_FAST       = CLK_HZ / INT_FAST_HZ;
    localparam int unsigned CONV_STEPS     = 12;
    localparam int unsigned CONV_CYC_SLOW  = CONV_STEPS * DIV_SLOW;
    localparam int unsigned CONV_CYC_FAST  = CONV_STEPS * DIV_FAST;
    localparam int unsigned EXT_STEPS      = 12;

    localparam int unsigned CNT_W          = 13;
    localparam int unsigned POR_W          = 10;
    localparam int unsigned RES_W          = 10;
    localparam int unsigned OUT_W          = 12;
    localparam int unsigned BYTE_W         = 8;
    localparam int unsigned MODE_LSB       = 0;
    localparam int unsigned MODE_MSB       = 1;

    localparam logic [1:0]  MODE_DEEP      = 2'h0;
    localparam logic [1:0]  MODE_QUICK     = 2'h1;
    localparam logic [1:0]  MODE_INT_CLK   = 2'h2;
    localparam logic [1:0]  MODE_EXT_CLK   = 2'h3;
    localparam logic [1:0]  MODE_RESET     = MODE_INT_CLK;
    localparam logic        STROBE_RESET   = 1'h1;
    localparam logic [3:0]  BIT_LAST       = 4'h7;
    localparam logic [3:0]  EXT_LAST       = 4'(EXT_STEPS - 1);
    localparam logic [1:0]  SUB_LSB_PAD    = 2'h0;

    typedef enum logic [2:0] {
        ADCPM_IDLE  = 3'h1,
        ADCPM_CONV  = 3'h2,
        ADCPM_SLEEP = 3'h4
    } adcpm_state_t;

endpackage

/* pkg/adcpm_if.sv */
// crossing signals between the link-clock front end and the core
`timescale 1ns/1ps
interface adcpm_if;
    logic [adcpm_pkg::BYTE_W-1:0] byte_data;
    logic                         byte_tgl;
    logic                         ext_tgl;
    logic [adcpm_pkg::RES_W-1:0]  res_data;
    logic                         res_tgl;

    modport core (
        input  byte_data,
        input  byte_tgl,
        input  ext_tgl,
        output res_data,
        output res_tgl
    );

    modport link (
        output byte_data,
        output byte_tgl,
        output ext_tgl,
        input  res_data,
        input  res_tgl
    );
endinterface

/* rtl/adcpm_link.sv */
// serial front end clocked by the host's serial clock
`timescale 1ns/1ps
module adcpm_link (
    input  wire logic sclk,
    input  wire logic resetn,
    input  wire logic cs_n,
    input  wire logic din,
    output logic      dout,
    adcpm_if.link     lnk
);

    typedef struct packed {
        logic [adcpm_pkg::BYTE_W-1:0] shreg;
        logic [3:0]                   bitcnt;
        logic                         rx;
        logic [adcpm_pkg::BYTE_W-1:0] byte_q;
        logic                         byte_tgl;
        logic                         ext_mode;
        logic                         ext_busy;
        logic [3:0]                   ext_cnt;
        logic                         ext_tgl;
        logic                         res_s1;
        logic                         res_s2;
        logic                         res_s3;
        logic [adcpm_pkg::OUT_W-1:0]  dout_sr;
    } adcpm_lnk_t;

    adcpm_lnk_t q, d;
    logic [adcpm_pkg::BYTE_W-1:0] nb;
    logic                         cm;

    always_comb begin
        d  = q;
        nb = {q.shreg[adcpm_pkg::BYTE_W-2:0], din};
        cm = q.ext_mode;
        d.res_s1 = lnk.res_tgl;
        d.res_s2 = q.res_s1;
        d.res_s3 = q.res_s2;
        // external-clock conversion steps ride on the serial clock itself
        if (q.ext_busy) begin
            d.ext_cnt = q.ext_cnt + 4'h1;
            if (q.ext_cnt == adcpm_pkg::EXT_LAST) begin
                d.ext_busy = 1'b0;
                d.ext_tgl  = ~q.ext_tgl;
            end
        end
        if (!cs_n) begin
            d.dout_sr = {q.dout_sr[adcpm_pkg::OUT_W-2:0], 1'b0};
            if (!q.rx) begin
                if (din) begin
                    d.rx     = 1'b1;
                    d.shreg  = nb;
                    d.bitcnt = 4'h1;
                end
            end else begin
                d.shreg  = nb;
                d.bitcnt = q.bitcnt + 4'h1;
                if (q.bitcnt == adcpm_pkg::BIT_LAST) begin
                    d.rx       = 1'b0;
                    d.byte_q   = nb;
                    d.byte_tgl = ~q.byte_tgl;
                    if (nb[adcpm_pkg::MODE_MSB]) begin
                        cm = nb[adcpm_pkg::MODE_LSB];
                    end
                    // power-down bytes keep the prior clock mode
                    d.ext_mode = cm;
                    d.ext_busy = cm;
                    d.ext_cnt  = 4'h0;
                end
            end
        end else begin
            d.rx = 1'b0;
        end
        // shifter holds zeros until a result arrives
        if (q.res_s2 != q.res_s3) begin
            d.dout_sr = {lnk.res_data, adcpm_pkg::SUB_LSB_PAD};
        end
    end

    always_ff @(posedge sclk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dout          = q.dout_sr[adcpm_pkg::OUT_W-1];
    assign lnk.byte_data = q.byte_q;
    assign lnk.byte_tgl  = q.byte_tgl;
    assign lnk.ext_tgl   = q.ext_tgl;

endmodule

/* rtl/adcpm_top.sv */
// power-mode and clock-mode control core with its serial front end
`timescale 1ns/1ps
module adcpm_top #(
    parameter int unsigned CONV_CYC_SLOW = adcpm_pkg::CONV_CYC_SLOW
) (
    input  wire logic                         CLK,
    input  wire logic                         RESETN,
    input  wire logic                         CE,
    input  wire logic                         SCLK,
    input  wire logic                         CS_N,
    input  wire logic                         DIN,
    output logic                              DOUT,
    output logic                              DOUT_OE,
    output logic                              CONVERSION_STROBE,
    output logic                              CONVERSION_STROBE_OE,
    input  wire logic                         HARD_POWERDOWN_REQ,
    input  wire logic                         INT_COMP_SEL,
    input  wire logic [adcpm_pkg::RES_W-1:0]  SAR_RESULT,
    output logic                              READY,
    output logic                              CONVERTING,
    output logic                              SAR_START,
    output logic                              CORE_EN,
    output logic                              BANDGAP_EN,
    output logic                              INT_COMP_EN,
    output logic                              CONV_CLK_FAST,
    output logic                              EXT_CLK_MODE,
    output logic                              DEEP_SLEEP,
    output logic                              QUICK_SLEEP,
    output logic                              MODE_BIT_HI,
    output logic                              MODE_BIT_LO
);

    typedef struct packed {
        logic                        hpd_s1;
        logic                        hpd_s2;
        logic                        cmp_s1;
        logic                        cmp_s2;
        logic                        cs_s1;
        logic                        cs_s2;
        logic                        byt_s1;
        logic                        byt_s2;
        logic                        byt_s3;
        logic                        ext_s1;
        logic                        ext_s2;
        logic                        ext_s3;
        logic [adcpm_pkg::POR_W-1:0] por_cnt;
        logic                        ready;
        logic [1:0]                  mode;
        logic                        clk_ext;
        logic                        conv_ext;
        adcpm_pkg::adcpm_state_t     state;
        logic [adcpm_pkg::CNT_W-1:0] cnt;
        logic [adcpm_pkg::RES_W-1:0] result;
        logic                        res_tgl;
        logic                        strobe;
        logic                        start;
    } adcpm_core_t;

    localparam logic [adcpm_pkg::CNT_W-1:0] LAST_SLOW = adcpm_pkg::CNT_W'(CONV_CYC_SLOW - 1);
    localparam logic [adcpm_pkg::CNT_W-1:0] LAST_FAST =
        adcpm_pkg::CNT_W'(adcpm_pkg::CONV_CYC_FAST - 1);
    localparam logic [adcpm_pkg::POR_W-1:0] POR_LAST =
        adcpm_pkg::POR_W'(adcpm_pkg::POR_CYCLES - 1);

    adcpm_core_t q, d;
    adcpm_if     xing ();

    logic                         byte_ev;
    logic                         ext_ev;
    logic                         hpd;
    logic                         int_comp;
    logic [adcpm_pkg::CNT_W-1:0]  conv_last;
    logic [adcpm_pkg::BYTE_W-1:0] ctrl_byte;
    logic [1:0]                   new_mode;
    logic                         finish;
    logic                         sleeping;

    adcpm_link adcpm_link_i (
        .sclk   (SCLK),
        .resetn (RESETN),
        .cs_n   (CS_N),
        .din    (DIN),
        .dout   (DOUT),
        .lnk    (xing.link)
    );

    // the byte stays still in the link domain until the next full byte,
    // so sampling it on the toggle edge is safe
    assign ctrl_byte = xing.byte_data;
    assign new_mode  = ctrl_byte[adcpm_pkg::MODE_MSB:adcpm_pkg::MODE_LSB];
    assign byte_ev   = q.byt_s2 ^ q.byt_s3;
    assign ext_ev    = q.ext_s2 ^ q.ext_s3;
    assign hpd       = q.hpd_s2;
    assign int_comp  = q.cmp_s2;

    // internal compensation runs the slow conversion clock
    // external compensation runs the fast conversion clock
    assign conv_last = int_comp ? LAST_SLOW : LAST_FAST;

    always_comb begin
        d       = q;
        finish  = 1'b0;
        d.start = 1'b0;

        d.hpd_s1 = HARD_POWERDOWN_REQ;
        d.hpd_s2 = q.hpd_s1;
        d.cmp_s1 = INT_COMP_SEL;
        d.cmp_s2 = q.cmp_s1;
        d.cs_s1  = CS_N;
        d.cs_s2  = q.cs_s1;
        d.byt_s1 = xing.byte_tgl;
        d.byt_s2 = q.byt_s1;
        d.byt_s3 = q.byt_s2;
        d.ext_s1 = xing.ext_tgl;
        d.ext_s2 = q.ext_s1;
        d.ext_s3 = q.ext_s2;

        // bytes before the reset interval ends are ignored
        if (!q.ready) begin
            d.por_cnt = q.por_cnt + adcpm_pkg::POR_W'(1);
            if (q.por_cnt == POR_LAST) begin
                d.ready = 1'b1;
            end
        end

        case (q.state)
            adcpm_pkg::ADCPM_CONV: begin
                if (q.conv_ext) begin
                    finish = ext_ev;
                end else begin
                    d.cnt  = q.cnt + adcpm_pkg::CNT_W'(1);
                    finish = (q.cnt >= conv_last);
                end
                if (finish) begin
                    // result kept through the following sleep
                    d.result  = SAR_RESULT;
                    d.res_tgl = ~q.res_tgl;
                    d.strobe  = 1'b1;
                    // mode 00 or 01 sleeps after one conversion
                    if (q.mode[adcpm_pkg::MODE_MSB]) begin
                        d.state = adcpm_pkg::ADCPM_IDLE;
                    end else begin
                        d.state = adcpm_pkg::ADCPM_SLEEP;
                    end
                end
            end
            adcpm_pkg::ADCPM_IDLE: begin
                d.cnt = '0;
            end
            adcpm_pkg::ADCPM_SLEEP: begin
                // only a new byte leaves sleep; no conversion here
                d.cnt = '0;
            end
            default: begin
                d.state  = adcpm_pkg::ADCPM_IDLE;
                d.strobe = adcpm_pkg::STROBE_RESET;
            end
        endcase

        // a new byte restarts conversion even mid-way, matching the part
        if (byte_ev && q.ready && !hpd) begin
            // mode register updates only on complete bytes
            d.mode = new_mode;
            // only clock-mode codes change the clock mode
            if (new_mode[adcpm_pkg::MODE_MSB]) begin
                d.clk_ext = new_mode[adcpm_pkg::MODE_LSB];
            end
            // power-down codes convert in the prior clock mode
            d.conv_ext = new_mode[adcpm_pkg::MODE_MSB] ?
                         new_mode[adcpm_pkg::MODE_LSB] : q.clk_ext;
            // conversion begins once the byte is in
            d.state    = adcpm_pkg::ADCPM_CONV;
            d.cnt      = '0;
            d.start    = 1'b1;
            // strobe low only for internal-clock conversions
            d.strobe   = d.conv_ext;
        end

        // hard power-down wins over the state, start, count and strobe set above
        if (hpd) begin
            if (q.state == adcpm_pkg::ADCPM_CONV) begin
                d.state = adcpm_pkg::ADCPM_IDLE;
            end
            d.start  = 1'b0;
            d.cnt    = '0;
            d.strobe = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            q          <= '0;
            // internal clock mode, strobe high, idle
            q.mode     <= adcpm_pkg::MODE_RESET;
            q.state    <= adcpm_pkg::ADCPM_IDLE;
            q.strobe   <= adcpm_pkg::STROBE_RESET;
            q.cs_s1    <= 1'b1;
            q.cs_s2    <= 1'b1;
        end else if (CE) begin
            q <= d;
        end
    end

    assign xing.res_data = q.result;
    assign xing.res_tgl  = q.res_tgl;

    assign sleeping = (q.state == adcpm_pkg::ADCPM_SLEEP);

    // deep sleep drops the bandgap too, quick sleep keeps it
    assign DEEP_SLEEP    = hpd | (sleeping & (q.mode == adcpm_pkg::MODE_DEEP));
    assign QUICK_SLEEP   = ~hpd & sleeping & (q.mode == adcpm_pkg::MODE_QUICK);
    assign BANDGAP_EN    = ~DEEP_SLEEP;
    assign CORE_EN       = ~hpd & ~sleeping;
    assign INT_COMP_EN   = ~hpd & int_comp;
    assign CONV_CLK_FAST = ~int_comp;
    assign EXT_CLK_MODE  = q.clk_ext;
    assign READY         = q.ready;
    assign CONVERTING    = (q.state == adcpm_pkg::ADCPM_CONV);
    assign SAR_START     = q.start;
    assign MODE_BIT_HI   = q.mode[adcpm_pkg::MODE_MSB];
    assign MODE_BIT_LO   = q.mode[adcpm_pkg::MODE_LSB];

    // strobe is always driven in internal clock mode; in external mode it
    // follows chip select, which reaches here through two flops
    assign CONVERSION_STROBE    = q.strobe;
    assign CONVERSION_STROBE_OE = ~q.clk_ext | ~q.cs_s2;
    assign DOUT_OE              = ~CS_N;

endmodule

/* tb/adcpm_chk.sv */
// port-level assertions for the power-mode control block
`timescale 1ns/1ps
module adcpm_chk #(
    parameter int unsigned CONV_CYC_SLOW = adcpm_pkg::CONV_CYC_SLOW
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic HARD_POWERDOWN_REQ,
    input wire logic INT_COMP_SEL,
    input wire logic CONVERSION_STROBE,
    input wire logic READY,
    input wire logic CONVERTING,
    input wire logic SAR_START,
    input wire logic CORE_EN,
    input wire logic BANDGAP_EN,
    input wire logic CONV_CLK_FAST,
    input wire logic DEEP_SLEEP,
    input wire logic QUICK_SLEEP,
    input wire logic MODE_BIT_HI,
    input wire logic MODE_BIT_LO
);
    localparam int unsigned LOW_MAX = 2 + ((CONV_CYC_SLOW > adcpm_pkg::CONV_CYC_FAST) ?
                                           CONV_CYC_SLOW : adcpm_pkg::CONV_CYC_FAST);
    logic [15:0] low_q;
    logic [15:0] low_d;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    always_comb begin
        low_d = CONVERSION_STROBE ? 16'h0 : low_q + 16'h1;
    end
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            low_q <= 16'h0;
        end else begin
            low_q <= low_d;
        end
    end

    chk_strobe_length: assert property (low_q <= LOW_MAX)
        else $error("strobe held low longer than a conversion");
    chk_strobe_on_start: assert property (
        SAR_START && MODE_BIT_HI && !MODE_BIT_LO |-> !CONVERSION_STROBE)
        else $error("strobe not low at internal conversion start");
    chk_strobe_while_conv: assert property (!CONVERSION_STROBE |-> CONVERTING)
        else $error("strobe low without a conversion");
    chk_ext_strobe_high: assert property (MODE_BIT_HI && MODE_BIT_LO |-> CONVERSION_STROBE)
        else $error("strobe low in external clock mode");
    chk_start_converts: assert property (SAR_START |-> CONVERTING)
        else $error("start pulse without conversion");
    chk_ready_gate: assert property (!READY |-> !SAR_START)
        else $error("conversion started before ready");
    chk_mode_hold: assert property (
        $changed({MODE_BIT_HI, MODE_BIT_LO}) |-> SAR_START)
        else $error("mode bits changed without a byte");
    chk_hard_abort: assert property (
        $rose(HARD_POWERDOWN_REQ) |-> ##[1:4] (!CONVERTING && DEEP_SLEEP && !CORE_EN))
        else $error("hard power-down did not stop the converter");
    chk_hard_hold: assert property (
        HARD_POWERDOWN_REQ [*4] |-> DEEP_SLEEP && !QUICK_SLEEP && !SAR_START)
        else $error("hard power-down overridden");
    chk_sleep_power: assert property (
        DEEP_SLEEP || QUICK_SLEEP |-> !CORE_EN && (BANDGAP_EN == !DEEP_SLEEP))
        else $error("sleep power enables wrong");
    chk_clk_slow_sel: assert property (INT_COMP_SEL [*4] |-> !CONV_CLK_FAST)
        else $error("fast clock with pin high");
    chk_clk_fast_sel: assert property (!INT_COMP_SEL [*4] |-> CONV_CLK_FAST)
        else $error("slow clock with pin floating");
endmodule

bind adcpm_top adcpm_chk #(.CONV_CYC_SLOW(CONV_CYC_SLOW)) adcpm_chk_i (
    .CLK(CLK), .RESETN(RESETN), .HARD_POWERDOWN_REQ(HARD_POWERDOWN_REQ),
    .INT_COMP_SEL(INT_COMP_SEL), .CONVERSION_STROBE(CONVERSION_STROBE), .READY(READY),
    .CONVERTING(CONVERTING), .SAR_START(SAR_START), .CORE_EN(CORE_EN),
    .BANDGAP_EN(BANDGAP_EN), .CONV_CLK_FAST(CONV_CLK_FAST), .DEEP_SLEEP(DEEP_SLEEP),
    .QUICK_SLEEP(QUICK_SLEEP), .MODE_BIT_HI(MODE_BIT_HI), .MODE_BIT_LO(MODE_BIT_LO));

/* tb/adcpm_host.sv */
// serial host model: shifts control bytes in and results out
`timescale 1ns/1ps
module adcpm_host (
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic dout
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din  = 1'b0;
    end

    // fixed 15 ns link period
    // link clock only runs inside a frame; data changes while it is low
    task automatic frame(input logic [31:0] bits, input int n, output logic [31:0] got);
        got = 32'h0;
        #3;
        cs_n = 1'b0;
        for (int k = n - 1; k >= 0; k--) begin
            din = bits[k];
            #7.5;
            sclk = 1'b1;
            #7.5;
            sclk = 1'b0;
            got = {got[30:0], dout};
        end
        #7.5;
        cs_n = 1'b1;
        // released line shows the inverse so a stale bit is never trusted
        din = ~din;
    endtask
endmodule

/* tb/test_adc_power_mode_control.sv */
// self-checking bench for the power-mode control block
`timescale 1ns/1ps
module test_adc_power_mode_control;
    localparam int SLOW = 60;
    logic                        clk, resetn, hpd, ics, ce;
    logic [adcpm_pkg::RES_W-1:0] res;
    logic                        dout, dout_oe, stb, stb_oe, ready, conv, start, core, bg;
    logic                        ice, fast, extm, deep, quick, mhi, mlo;
    wire                         sclk, cs_n, din;
    int                          mismatches = 0;
    int                          check_count = 0;
    int                          cyc = 0;

    adcpm_top #(.CONV_CYC_SLOW(SLOW)) adcpm_top_i (
        .CLK(clk), .RESETN(resetn), .CE(ce), .SCLK(sclk), .CS_N(cs_n), .DIN(din),
        .DOUT(dout), .DOUT_OE(dout_oe), .CONVERSION_STROBE(stb),
        .CONVERSION_STROBE_OE(stb_oe), .HARD_POWERDOWN_REQ(hpd), .INT_COMP_SEL(ics),
        .SAR_RESULT(res), .READY(ready), .CONVERTING(conv), .SAR_START(start),
        .CORE_EN(core), .BANDGAP_EN(bg), .INT_COMP_EN(ice), .CONV_CLK_FAST(fast),
        .EXT_CLK_MODE(extm), .DEEP_SLEEP(deep), .QUICK_SLEEP(quick),
        .MODE_BIT_HI(mhi), .MODE_BIT_LO(mlo));
    adcpm_host adcpm_host_i (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic wait_start();
        int i;
        i = 0;
        while (start !== 1'b1 && i < 20) begin
            @(negedge clk);
            i++;
        end
        check(start, 1'b1);
    endtask

    // four leading zeros before the start bit of every byte
    task automatic convert(input logic [7:0] b, output int low);
        logic [31:0] g;
        low = 0;
        adcpm_host_i.frame({24'h0, b}, 12, g);
        wait_start();
        check(stb, 24'(b[1:0] == 2'h3));
        if (b[1:0] == 2'h3) adcpm_host_i.frame(32'h0, 16, g);
        for (int i = 0; i < 3000 && conv === 1'b1; i++) begin
            @(negedge clk);
            low += int'(stb === 1'b0);
        end
    endtask

    task automatic read_check(input logic [23:0] exp);
        logic [31:0] g;
        adcpm_host_i.frame(32'h0, 24, g);
        check(g[23:0], exp);
    endtask

    task automatic t_reset();
        logic [31:0] g;
        longint t0;
        check({stb, mhi, mlo, ready, start}, 5'h18);
        @(negedge clk);
        resetn = 1'b1;
        t0 = $time;
        adcpm_host_i.frame(32'h81, 12, g);
        // host sends a byte before the reset interval ends; it must be ignored
        for (int i = 0; i < 1100 && ready !== 1'b1; i++) @(negedge clk);
        check(24'(($time - t0) / 10 >= 999 && ($time - t0) / 10 <= 1001), 24'h1);
        check({mhi, mlo, stb}, 3'h5);
        read_check(24'h0);
    endtask

    task automatic t_internal();
        int low;
        repeat (500) @(negedge clk);
        res = 10'h2a5;
        convert(8'h8e, low);
        check(24'(low >= SLOW - 1 && low <= SLOW + 1), 24'h1);
        check({fast, extm, core, ice}, 4'h3);
        check({stb_oe, dout_oe}, 2'h2);
        read_check({2'h0, res, 12'h0});
    endtask

    task automatic t_sleep();
        int low;
        @(negedge clk);
        res = 10'h15a;
        convert(8'h80, low);
        check({deep, quick, core, bg}, 4'h8);
        read_check({2'h0, res, 12'h0});
        convert(8'h81, low);
        check({deep, quick, core, bg}, 4'h5);
        convert(8'h8e, low);
        check({deep, quick, core, bg}, 4'h3);
    endtask

    task automatic t_external();
        int low;
        @(negedge clk);
        ics = 1'b0;
        repeat (500) @(negedge clk);
        convert(8'h8f, low);
        check(24'(low), 24'h0);
        check({fast, extm, mhi, mlo, ice}, 5'h1e);
        // strobe enable follows chip select through two flops
        repeat (3) @(negedge clk);
        check({stb_oe, dout_oe}, 2'h0);
    endtask

    task automatic t_hard();
        logic [31:0] g;
        adcpm_host_i.frame(32'h8e, 12, g);
        wait_start();
        // clock enable low must freeze the start pulse and the count
        ce = 1'b0;
        repeat (10) @(negedge clk);
        check({conv, start}, 2'h3);
        ce = 1'b1;
        repeat (10) @(negedge clk);
        hpd = 1'b1;
        repeat (4) @(negedge clk);
        check({conv, stb, deep, core}, 4'h6);
        adcpm_host_i.frame(32'h81, 12, g);
        repeat (8) @(negedge clk);
        check({conv, mhi, mlo}, 3'h2);
        hpd = 1'b0;
        repeat (4) @(negedge clk);
        check({deep, core}, 2'h1);
        // host trusts power after 2 us
        repeat (200) @(negedge clk);
        check({core, bg, ready}, 3'h7);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // output enable must follow chip select during every frame
    always @(negedge sclk) begin
        if (cs_n === 1'b0) check(dout_oe, 1'b1);
    end

    // whole run needs a few thousand cycles; this ceiling catches a hang
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            results();
        end
    end

    initial begin
        resetn = 1'b0;
        hpd = 1'b0;
        ics = 1'b1;
        ce = 1'b1;
        res = '0;
        repeat (2) @(negedge clk);
        t_reset();
        t_internal();
        t_sleep();
        t_external();
        t_hard();
        results();
    end
endmodule
